/* design/qdr_defines.svh */
// Purpose: shared constants for the quad-channel readback two-wire link
// Assumes: link clock made by the master end through a divider of ref_clk_i
// Notes: counts are in ref_clk_i cycles
`ifndef QDR_DEFINES_SVH
`define QDR_DEFINES_SVH
`define QDR_ADDR_FIXED 5'h13
`define QDR_PD_FILL 6'h3F
`define QDR_HS_CODE_HI 5'h01
`define QDR_SCL_HALF 4'h4
`define QDR_SCL_HALF_W 4
`endif

/* design/qdr_pkg.sv */
// Purpose: types used by the device end
// Assumes: nothing beyond the defines header
// Notes: states are one-hot
package qdr_pkg;
    typedef enum logic [4:0] {
        QDR_S_IDLE = 5'h01,
        QDR_S_RX = 5'h02,
        QDR_S_ACK = 5'h04,
        QDR_S_TX = 5'h08,
        QDR_S_MACK = 5'h10
    } qdr_dev_st_t;
    typedef logic [11:0] qdr_code_t;
endpackage : qdr_pkg

/* design/qdr_link_if.sv */
// Purpose: two-wire link joining master end and device end
// Assumes: open-drain wires, pulled high when nobody drives
// Notes: wire levels resolved from the output enables here
`timescale 1ns/100ps
interface qdr_link_if;
    logic scl_oe;
    logic sda_m_oe;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // open-drain resolve: any enable pulls low
    assign scl = ~scl_oe;
    assign sda = ~(sda_m_oe | sda_d_oe);
    modport master (output scl_oe, output sda_m_oe, input scl, input sda);
    modport device (output sda_d_oe, input scl, input sda);
endinterface : qdr_link_if

/* design/qdr_device.sv */
// Purpose: device end, slave-transmitter readback of four 12-bit channels
// Assumes: link pins sampled through two flops on ref_clk_i
// Notes: channel contents and power-down bits come in from the core as levels
`timescale 1ns/100ps
`include "qdr_defines.svh"
// Summary of operation
// [R01] address is 10011 plus two pins, R/W
// [R02] write address acknowledged by pulling data low
// [R03] control byte acknowledged, select and flag kept
// [R04] read address acknowledged, then bytes driven
// [R05] flag 0: high byte then low byte
// [R06] flag 1: power-down, high, low bytes
// [R07] latest select bits choose returned channel
// [R08] power-down byte: mode bits, then six ones
// [R09] high byte holds code bits 11..4
// [R10] low byte holds bits 3..0, rest zero
// [R11] master acks all bytes but the last
// [R12] master stops after the final byte
// [R13] master may use repeated start instead
// [R14] master sends high-speed code at slow speed
// [R15] device never acknowledges high-speed code
// [R16] same sequence follows at higher rate; the master here keeps one divider, so the link clock rate is unchanged
// [R17] control byte lsb is the power-down flag
// [R18] after final nack release data, go idle
// [R19] select 00..11 maps to channels one..four
module qdr_device (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic addr_pin_hi_i,
    input wire logic addr_pin_lo_i,
    input wire logic [47:0] chan_code_i,
    input wire logic [7:0] chan_pd_mode_i,
    output logic [1:0] chan_sel_o,
    output logic powerdown_flag_o,
    output logic busy_o,
    qdr_link_if.device link
);
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic [1:0] apin_s1_q, apin_s2_q;
    qdr_pkg::qdr_dev_st_t st_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [1:0] nbytes_q;
    logic rd_q;
    logic ctrl_next_q;
    logic sda_oe_q;
    logic [1:0] sel_q;
    logic pdf_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [6:0] my_addr;
    qdr_pkg::qdr_code_t code_sel;
    logic [1:0] pd_sel;
    logic [7:0] tx_byte;

    // two-flop synchronisers, third stage only for edge finding
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
            apin_s1_q <= 2'h0;
            apin_s2_q <= 2'h0;
        end else if (clk_en_i) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {link.scl, scl_s1_q, scl_s2_q};
            // address pins are board levels, so they are synchronised as well
            apin_s1_q <= {addr_pin_hi_i, addr_pin_lo_i};
            apin_s2_q <= apin_s1_q;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {link.sda, sda_s1_q, sda_s2_q};
        end
    end

    // edges and bus conditions from synchronised levels only
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_c = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    assign stop_c = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
    assign my_addr = {`QDR_ADDR_FIXED, apin_s2_q}; // R01

    // channel pick by index, 00 first channel
    always_comb begin
        code_sel = chan_code_i[sel_q*12 +: 12]; // R07 R19
        pd_sel = chan_pd_mode_i[sel_q*2 +: 2];
        unique case (byte_q)
            2'h0: tx_byte = pdf_q ? {pd_sel, `QDR_PD_FILL} : code_sel[11:4]; // R06 R08 R09
            2'h1: tx_byte = pdf_q ? code_sel[11:4] : {code_sel[3:0], 4'h0}; // R05 R10
            default: tx_byte = {code_sel[3:0], 4'h0}; // R10
        endcase
    end

    // protocol engine; start also covers repeated start, so high-speed entry is seamless
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q <= qdr_pkg::QDR_S_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            nbytes_q <= 2'h0;
            rd_q <= 1'b0;
            ctrl_next_q <= 1'b0;
            sda_oe_q <= 1'b0;
            sel_q <= 2'h0;
            pdf_q <= 1'b0;
        end else if (clk_en_i) begin
            if (start_c) begin // R16
                st_q <= qdr_pkg::QDR_S_RX;
                bit_q <= 4'h0;
                // byte index must not carry over from the previous read
                byte_q <= 2'h0;
                ctrl_next_q <= 1'b0;
                sda_oe_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= qdr_pkg::QDR_S_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                unique case (st_q)
                    qdr_pkg::QDR_S_IDLE: sda_oe_q <= 1'b0;
                    qdr_pkg::QDR_S_RX: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_s2_q};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (ctrl_next_q) begin
                                sel_q <= sh_q[2:1]; // R03 R07
                                pdf_q <= sh_q[0]; // R17
                                ctrl_next_q <= 1'b0;
                                sda_oe_q <= 1'b1; // R03
                                st_q <= qdr_pkg::QDR_S_ACK;
                            end else if (sh_q[7:1] == my_addr) begin
                                rd_q <= sh_q[0];
                                ctrl_next_q <= ~sh_q[0];
                                sda_oe_q <= 1'b1; // R02 R04
                                st_q <= qdr_pkg::QDR_S_ACK;
                            end else begin
                                // other address or high-speed code: stay silent
                                st_q <= qdr_pkg::QDR_S_IDLE; // R15
                            end
                        end
                    end
                    qdr_pkg::QDR_S_ACK: begin
                        if (scl_fall) begin
                            if (rd_q) begin
                                byte_q <= 2'h0;
                                nbytes_q <= pdf_q ? 2'h3 : 2'h2; // R05 R06
                                sh_q <= tx_byte;
                                sda_oe_q <= 1'b0;
                                st_q <= qdr_pkg::QDR_S_TX;
                            end else begin
                                sda_oe_q <= 1'b0;
                                st_q <= qdr_pkg::QDR_S_RX;
                            end
                        end
                    end
                    qdr_pkg::QDR_S_TX: begin
                        // drive low when current bit is zero; shift on falling edge
                        sda_oe_q <= ~sh_q[7]; // R04
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                bit_q <= 4'h0;
                                sda_oe_q <= 1'b0;
                                st_q <= qdr_pkg::QDR_S_MACK;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                sh_q <= {sh_q[6:0], 1'b1};
                            end
                        end
                    end
                    qdr_pkg::QDR_S_MACK: begin
                        sda_oe_q <= 1'b0;
                        if (scl_rise) begin
                            if (sda_s2_q || byte_q + 2'h1 == nbytes_q) begin
                                st_q <= qdr_pkg::QDR_S_IDLE; // R18 R11
                                rd_q <= 1'b0;
                            end else begin
                                byte_q <= byte_q + 2'h1;
                            end
                        end else if (scl_fall) begin
                            sh_q <= tx_byte;
                            st_q <= qdr_pkg::QDR_S_TX;
                        end
                    end
                    default: st_q <= qdr_pkg::QDR_S_IDLE;
                endcase
            end
        end
    end

    assign link.sda_d_oe = sda_oe_q;
    assign chan_sel_o = sel_q;
    assign powerdown_flag_o = pdf_q;
    assign busy_o = (st_q != qdr_pkg::QDR_S_IDLE);
endmodule : qdr_device

/* design/qdr_master.sv */
// Purpose: master end, runs one readback: write address, control, read address, bytes
// Assumes: it makes the link clock from ref_clk_i by a divider
// Notes: optional high-speed code sent first; the rate itself is not changed here
`timescale 1ns/100ps
`include "qdr_defines.svh"
module qdr_master (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic go_i,
    input wire logic hs_i,
    input wire logic [1:0] dev_addr_i,
    input wire logic [7:0] ctrl_i,
    output logic ready_o,
    output logic done_o,
    output logic nack_o,
    output logic [23:0] rdata_o,
    qdr_link_if.master link
);
    // step codes of a flat sequencer; each half_q step is one quarter scl period
    logic [3:0] div_q;
    logic tick;
    logic busy_q;
    logic [3:0] ph_q;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [2:0] nrd_q;
    logic [7:0] sh_q;
    logic scl_oe_q, sda_oe_q;
    logic [23:0] rd_q;
    logic nack_q, done_q;
    logic [1:0] half_q;
    logic sda_s1_q, sda_s2_q;

    // data pin synchroniser
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) {sda_s1_q, sda_s2_q} <= 2'h3;
        else if (clk_en_i) {sda_s1_q, sda_s2_q} <= {link.sda, sda_s1_q};
    end

    // divider: quarter period ticks
    assign tick = (div_q == `QDR_SCL_HALF);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !busy_q) div_q <= 4'h0;
        else if (clk_en_i) div_q <= tick ? 4'h0 : div_q + 4'h1;
    end

    // byte to send per byte slot: 0 hs code, 1 waddr, 2 ctrl, 3 raddr, 4+ reads
    function automatic logic [7:0] qdr_tx_byte(input logic [2:0] b, input logic [1:0] a,
                                               input logic [7:0] c);
        unique case (b)
            3'h0: qdr_tx_byte = {`QDR_HS_CODE_HI, 3'h0};
            3'h1: qdr_tx_byte = {`QDR_ADDR_FIXED, a, 1'b0};
            3'h2: qdr_tx_byte = c;
            default: qdr_tx_byte = {`QDR_ADDR_FIXED, a, 1'b1};
        endcase
    endfunction : qdr_tx_byte

    // ph: 0 start, 1 data bits, 2 ack bit, 3 repeated start, 4 stop
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0; ph_q <= 4'h0; bit_q <= 4'h0; byte_q <= 3'h0;
            nrd_q <= 3'h0; sh_q <= 8'h00; scl_oe_q <= 1'b0; sda_oe_q <= 1'b0;
            rd_q <= 24'h000000; nack_q <= 1'b0; done_q <= 1'b0; half_q <= 2'h0;
        end else if (clk_en_i) begin
            done_q <= 1'b0;
            if (!busy_q) begin
                if (go_i) begin
                    busy_q <= 1'b1; ph_q <= 4'h0; half_q <= 2'h0; nack_q <= 1'b0;
                    byte_q <= hs_i ? 3'h0 : 3'h1; // R14
                    sh_q <= qdr_tx_byte(hs_i ? 3'h0 : 3'h1, dev_addr_i, ctrl_i);
                    nrd_q <= ctrl_i[0] ? 3'h3 : 3'h2;
                end
            end else if (tick) begin
                half_q <= half_q + 2'h1;
                unique case (ph_q)
                    4'h0: begin // start: data low while clock high, then clock low
                        if (half_q == 2'h0) sda_oe_q <= 1'b1;
                        else begin scl_oe_q <= 1'b1; half_q <= 2'h0; ph_q <= 4'h1; bit_q <= 4'h0; end
                    end
                    4'h1: begin
                        if (half_q == 2'h0) sda_oe_q <= (byte_q < 3'h4) ? ~sh_q[7] : 1'b0;
                        else if (half_q == 2'h1) scl_oe_q <= 1'b0;
                        else if (half_q == 2'h2) begin
                            if (byte_q >= 3'h4) sh_q <= {sh_q[6:0], sda_s2_q};
                            else sh_q <= {sh_q[6:0], 1'b0};
                        end else begin
                            scl_oe_q <= 1'b1;
                            half_q <= 2'h0;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7) ph_q <= 4'h2;
                        end
                    end
                    4'h2: begin
                        // reads: ack all but last; writes: release and sample
                        if (half_q == 2'h0) sda_oe_q <= (byte_q >= 3'h4) &&
                                                        (byte_q - 3'h3 != nrd_q); // R11
                        else if (half_q == 2'h1) scl_oe_q <= 1'b0;
                        else if (half_q == 2'h2) begin
                            if (byte_q >= 3'h4) rd_q <= {rd_q[15:0], sh_q};
                            else if (sda_s2_q && byte_q != 3'h0) nack_q <= 1'b1;
                        end else begin
                            scl_oe_q <= 1'b1; half_q <= 2'h0; bit_q <= 4'h0;
                            if (nack_q || (byte_q >= 3'h4 && byte_q - 3'h3 == nrd_q))
                                ph_q <= 4'h4; // R12
                            else if (byte_q == 3'h0 || byte_q == 3'h2) begin
                                ph_q <= 4'h3; // R16
                                byte_q <= byte_q + 3'h1;
                                sh_q <= qdr_tx_byte(byte_q + 3'h1, dev_addr_i, ctrl_i);
                            end else begin
                                ph_q <= 4'h1;
                                byte_q <= byte_q + 3'h1;
                                sh_q <= qdr_tx_byte(byte_q + 3'h1, dev_addr_i, ctrl_i);
                            end
                        end
                    end
                    4'h3: begin // repeated start: free data, raise clock, then start R13
                        if (half_q == 2'h0) sda_oe_q <= 1'b0;
                        else begin scl_oe_q <= 1'b0; half_q <= 2'h0; ph_q <= 4'h0; end
                    end
                    default: begin // stop: data low, clock high, data high
                        if (half_q == 2'h0) sda_oe_q <= 1'b1;
                        else if (half_q == 2'h1) scl_oe_q <= 1'b0;
                        else begin
                            sda_oe_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign link.scl_oe = scl_oe_q;
    assign link.sda_m_oe = sda_oe_q;
    assign ready_o = ~busy_q;
    assign done_o = done_q;
    assign nack_o = nack_q;
    assign rdata_o = rd_q;
endmodule : qdr_master

/* verif/qdr_link_assertions.sv */
// Purpose: wire checks on the two-wire readback link
// Assumes: both ends are design modules on one qdr_link_if
// Notes: a small decoder follows bit slot, byte count, direction and flag
`timescale 1ns/100ps
`include "qdr_defines.svh"
module qdr_link_assertions (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic [3:0] bcnt_q;
    logic [7:0] sh_q;
    logic [2:0] nbyte_q;
    logic rd_q;
    logic pdf_q;
    logic rise;
    logic start;
    logic stop;
    logic ack_slot;
    logic last_rd;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // edges and conditions seen on the resolved wires
    assign rise = scl & ~scl_q;
    assign start = scl & scl_q & ~sda & sda_q;
    assign stop = scl & scl_q & sda & ~sda_q;
    assign ack_slot = rise && (bcnt_q == 4'h8);
    assign last_rd = rd_q && (nbyte_q == (pdf_q ? 3'h3 : 3'h2));
    // bit slot and shifted byte, restarted by every start
    always_ff @(posedge ref_clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
        if (sys_rst_i || start) begin
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
        end else if (rise) begin
            bcnt_q <= (bcnt_q == 4'h8) ? 4'h0 : bcnt_q + 4'h1;
            if (bcnt_q != 4'h8) begin
                sh_q <= {sh_q[6:0], sda};
            end
        end
    end
    // byte count, read direction only once the address is acked
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            nbyte_q <= 3'h0;
            rd_q <= 1'b0;
            pdf_q <= 1'b0;
        end else if (start) begin
            nbyte_q <= 3'h0;
            rd_q <= 1'b0;
        end else if (ack_slot) begin
            nbyte_q <= (nbyte_q == 3'h7) ? nbyte_q : nbyte_q + 3'h1;
            if (nbyte_q == 3'h0) begin
                rd_q <= sh_q[0] & ~sda;
            end
            if (nbyte_q == 3'h1 && !rd_q) begin
                pdf_q <= sh_q[0];
            end
        end
    end
    a_hs_no_ack: assert property (ack_slot && nbyte_q == 3'h0 &&
        sh_q[7:3] == `QDR_HS_CODE_HI |-> !sda_d_oe) else $error("code byte acked");
    a_foreign_no_ack: assert property (ack_slot && nbyte_q == 3'h0 &&
        sh_q[7:3] != `QDR_ADDR_FIXED |-> !sda_d_oe) else $error("foreign acked");
    a_pd_fill: assert property (ack_slot && rd_q && pdf_q && nbyte_q == 3'h1
        |-> sh_q[5:0] == `QDR_PD_FILL) else $error("power-down fill wrong");
    a_low_nibble: assert property (ack_slot && last_rd
        |-> sh_q[3:0] == 4'h0) else $error("low nibble not zero");
    a_master_ack: assert property (ack_slot && rd_q && nbyte_q != 3'h0
        |-> sda == last_rd) else $error("master ack wrong");
    a_read_release: assert property (ack_slot && rd_q && nbyte_q != 3'h0
        |-> !sda_d_oe && sda_m_oe != last_rd) else $error("data held at ack");
    a_data_steady: assert property (scl && scl_q |-> $stable(sda_d_oe))
        else $error("device data moved while clock high");
    a_byte_total: assert property (stop && rd_q
        |-> nbyte_q == (pdf_q ? 3'h4 : 3'h3)) else $error("read byte count");
    a_stop_release: assert property (stop |=> !sda_d_oe [*8])
        else $error("data not released after stop");
    c_read3: cover property (stop && rd_q && pdf_q);
    c_read2: cover property (stop && rd_q && !pdf_q);
    c_hs_code: cover property (ack_slot && nbyte_q == 3'h0 && sh_q[7:3] == `QDR_HS_CODE_HI);
endmodule : qdr_link_assertions

/* verif/testbench.sv */
// Purpose: both link ends back to back, readback of all channels
// Assumes: master end makes the link clock by its divider
// Notes: driver queues expectations, a monitor compares at each done
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic [23:0] d; logic [23:0] m; logic nk;} qdr_exp_t;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic go_i = 1'b0;
    logic clk_en = 1'b1;
    logic hs_i = 1'b0;
    logic [1:0] pins = 2'h0;
    logic [1:0] dev_addr_i = 2'h0;
    logic [7:0] ctrl_i = 8'h00;
    logic [47:0] codes = 48'h0;
    logic [7:0] modes = 8'h00;
    logic ready_o, done_o, nack_o, pdf;
    logic [23:0] rdata_o;
    logic [1:0] sel;
    qdr_exp_t exp_q[$];
    qdr_exp_t ex;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int tnum = 0;
    qdr_link_if link_i();
    qdr_device qdr_device_i(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .addr_pin_hi_i(pins[1]), .addr_pin_lo_i(pins[0]), .chan_code_i(codes),
        .chan_pd_mode_i(modes), .chan_sel_o(sel), .powerdown_flag_o(pdf), .busy_o(),
        .link(link_i));
    qdr_master qdr_master_i(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .go_i(go_i), .hs_i(hs_i), .dev_addr_i(dev_addr_i), .ctrl_i(ctrl_i),
        .ready_o(ready_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o),
        .link(link_i));
    qdr_link_assertions qdr_link_assertions_i(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .scl_oe(link_i.scl_oe), .sda_m_oe(link_i.sda_m_oe), .sda_d_oe(link_i.sda_d_oe),
        .scl(link_i.scl), .sda(link_i.sda));
    // 25 MHz reference clock
    always #20 ref_clk_i = ~ref_clk_i;
    // random freezes of both ends mid-transfer; never while done stands
    always @(negedge ref_clk_i) begin
        clk_en = (ready_o !== 1'b0) || (done_o === 1'b1) || ($urandom % 16 != 0);
    end
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // one readback; ok low aims at a foreign address so nobody acks
    task automatic run(input logic [1:0] ch, input logic pd, input logic hs, input logic ok);
        logic [11:0] c;
        int n;
        c = codes[ch*12 +: 12];
        @(negedge ref_clk_i);
        hs_i = hs;
        ctrl_i = {2'b00, 3'($urandom), ch, pd};
        dev_addr_i = ok ? pins : ~pins;
        if (!ok) begin
            exp_q.push_back('{24'h0, 24'h0, 1'b1});
        end else if (pd) begin
            exp_q.push_back('{{modes[ch*2 +: 2], 6'h3F, c, 4'h0}, 24'hFFFFFF, 1'b0});
        end else begin
            exp_q.push_back('{{8'h00, c, 4'h0}, 24'h00FFFF, 1'b0});
        end
        go_i = 1'b1;
        @(negedge ref_clk_i);
        go_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 4000) chk("done wait", 24'h1, 24'h0);
        if (ok) chk("channel select", {22'h0, ch}, {22'h0, sel});
        if (ok) chk("power-down flag", {23'h0, pd}, {23'h0, pdf});
        tnum++;
        $display("test %0d done", tnum);
    endtask : run
    // monitor takes the oldest expectation at each completion pulse
    always @(negedge ref_clk_i) begin
        if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected done", 24'h0, 24'h1);
            end else begin
                ex = exp_q.pop_front();
                chk("read data", ex.d, rdata_o & ex.m);
                chk("nack", {23'h0, ex.nk}, {23'h0, nack_o});
            end
        end
    end
    // hang guard, well above thirteen transfers
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            stop_test();
        end
    end
    // main sequence: every channel, both flag values, with and without the high-speed code
    initial begin
        void'($urandom(32'hF8E6));
        repeat (5) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            codes = 48'({$urandom, $urandom});
            modes = 8'($urandom);
            pins = 2'(i);
            run(2'(i), i[2], i[0] ^ i[2], 1'b1);
        end
        for (int j = 0; j < 2; j++) begin
            codes = j ? 48'hFFFFFFFFFFFF : 48'h0;
            modes = j ? 8'hFF : 8'h00;
            run(2'(j + 2), 1'b1, 1'b0, 1'b1);
        end
        run(2'h1, 1'b0, 1'b1, 1'b0);
        run(2'h2, 1'b1, 1'b0, 1'b0);
        run(2'h2, 1'b1, 1'b1, 1'b1);
        stop_test();
    end
endmodule : testbench
